/* File: sem_top.sv */
// Socket status-change flags, interrupt mask and status-change interrupt.
// Notes on behaviour
// - Each flag records only that a change happened; a written 1 clears it.
// - Writing 1 to a force bit sets the matching flag like a real change.
// - Bus reset clears all flags where that reset applies to them.
// - After card reset, flag bits 2 to 0 set again at once if their status is still present.
// - Interrupt asserts while enabled and any unmasked flag is set.
// - Flag bit 3 sets when the socket power state changes.
// - Flag bit 2 sets when the second card-detect status changes.
// - Flag bit 1 sets when the first card-detect status changes.
// - Flag bit 0: rising edge for bus-mastering cards, both edges for 16-bit cards.
// - Bits 31 to 4 of both registers read as zero.
// - Mask bit 3 gates the power event interrupt; default 0.
// - Mask bits 2:1 gate card-detect interrupts; 11 enables, 00 blocks.
// - Mask bit 0 gates the card status interrupt; default 0.
// - Mask bits affect only the interrupt, never flag setting.
// - With power events enabled only global reset clears; else bus reset too.
// - Both registers reset to zero.
`timescale 1ns/1ps
`include "sem_map.svh"
module sem_top (
  // Clock and global reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus reset and power-management event enable.
  input wire logic bus_reset,
  input wire logic pme_enable,
  // Register access port.
  input wire sem_pkg::sem_addr_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire sem_pkg::sem_word_t reg_wdata,
  output sem_pkg::sem_word_t reg_rdata,
  // Force-event write strobe with its data.
  input wire logic force_wr,
  input wire sem_pkg::sem_bits_t force_bits,
  // Monitored socket status.
  input wire logic socket_power_state,
  input wire logic detect_one_state,
  input wire logic detect_two_state,
  input wire logic card_status_state,
  input wire logic card_is_16bit,
  input wire logic card_reset,
  // Interrupt enable and status-change interrupt.
  input wire logic irq_global_en,
  output logic status_change_interrupt
);
  import sem_pkg::*;

  sem_bits_t flags_q;
  sem_bits_t flags_d;
  sem_bits_t irq_en_q;
  sem_bits_t irq_en_d;
  sem_word_t rdata_q;
  sem_word_t rdata_d;
  logic irq_q;
  logic irq_d;
  logic card_reset_q;
  logic card_reset_d;
  sem_bits_t change;
  sem_bits_t set_req;
  sem_bits_t clr_req;
  sem_bits_t unmasked;
  logic soft_clear;
  logic reset_exit;

  // One change detector per monitored line.
  sem_edge u_pwr (
    .clk_sys(clk_sys), .reset_n(reset_n), .level(socket_power_state),
    .rise_only(1'b0), .change(change[`SEM_BIT_PWR]));
  sem_edge u_cd2 (
    .clk_sys(clk_sys), .reset_n(reset_n), .level(detect_two_state),
    .rise_only(1'b0), .change(change[`SEM_BIT_CD2]));
  sem_edge u_cd1 (
    .clk_sys(clk_sys), .reset_n(reset_n), .level(detect_one_state),
    .rise_only(1'b0), .change(change[`SEM_BIT_CD1]));
  sem_edge u_csts (
    .clk_sys(clk_sys), .reset_n(reset_n), .level(card_status_state),
    .rise_only(~card_is_16bit), .change(change[`SEM_BIT_CSTS]));

  // Bus reset clears state only when power-management events are off.
  assign soft_clear = bus_reset & ~pme_enable;
  assign reset_exit = card_reset_q & ~card_reset;

  always_comb begin
    card_reset_d = card_reset;
    set_req = change;
    if (force_wr) begin
      set_req = set_req | force_bits;
    end
    if (reset_exit) begin
      // Status still present after card reset is reported again.
      set_req[`SEM_BIT_CD1] = set_req[`SEM_BIT_CD1] | detect_one_state;
      set_req[`SEM_BIT_CD2] = set_req[`SEM_BIT_CD2] | detect_two_state;
      set_req[`SEM_BIT_CSTS] = set_req[`SEM_BIT_CSTS] | card_status_state;
    end
    clr_req = '0;
    if (reg_wr && reg_addr == `SEM_OFS_FLAGS) begin
      clr_req = reg_wdata[`SEM_NBITS-1:0];
    end
    if (soft_clear) begin
      flags_d = `SEM_RST_FLAGS;
    end else begin
      flags_d = (flags_q & ~clr_req) | set_req;
    end
  end

  always_comb begin
    irq_en_d = irq_en_q;
    if (soft_clear) begin
      irq_en_d = `SEM_RST_IRQ_EN;
    end else if (reg_wr && reg_addr == `SEM_OFS_IRQ_EN) begin
      irq_en_d = reg_wdata[`SEM_NBITS-1:0];
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        `SEM_OFS_FLAGS: rdata_d = {`SEM_ZERO_HI, flags_q};
        `SEM_OFS_IRQ_EN: rdata_d = {`SEM_ZERO_HI, irq_en_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // Card-detect events need both mask bits set; 01 and 10 act as blocked.
  always_comb begin
    unmasked[`SEM_BIT_PWR] = flags_q[`SEM_BIT_PWR] & irq_en_q[`SEM_BIT_PWR];
    unmasked[`SEM_BIT_CD2] = flags_q[`SEM_BIT_CD2] & irq_en_q[`SEM_BIT_CD2] & irq_en_q[`SEM_BIT_CD1];
    unmasked[`SEM_BIT_CD1] = flags_q[`SEM_BIT_CD1] & irq_en_q[`SEM_BIT_CD2] & irq_en_q[`SEM_BIT_CD1];
    unmasked[`SEM_BIT_CSTS] = flags_q[`SEM_BIT_CSTS] & irq_en_q[`SEM_BIT_CSTS];
    irq_d = irq_global_en & (|unmasked);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= `SEM_RST_FLAGS;
      irq_en_q <= `SEM_RST_IRQ_EN;
      rdata_q <= '0;
      irq_q <= 1'b0;
      card_reset_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_en_q <= irq_en_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      card_reset_q <= card_reset_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign status_change_interrupt = irq_q;

  sequence s_force_one;
    force_wr && !soft_clear && force_bits[`SEM_BIT_PWR];
  endsequence

  AST_FORCE_SETS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_force_one |=> flags_q[`SEM_BIT_PWR]) else $error("Force write did not set flag.");
  AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!soft_clear && change[`SEM_BIT_CD1] && reg_wr && reg_addr == `SEM_OFS_FLAGS)
    |=> flags_q[`SEM_BIT_CD1]) else $error("Clear beat a same-cycle set.");
  AST_W1C: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == `SEM_OFS_FLAGS && reg_wdata[`SEM_BIT_PWR] && set_req == '0)
    |=> !flags_q[`SEM_BIT_PWR]) else $error("Write of one did not clear flag.");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (flags_q[`SEM_BIT_CSTS] && !soft_clear && !(reg_wr && reg_addr == `SEM_OFS_FLAGS))
    |=> flags_q[`SEM_BIT_CSTS]) else $error("Flag dropped without a clear.");
  AST_BUS_RESET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    soft_clear |=> (flags_q == '0 && irq_en_q == '0)) else $error("Bus reset did not clear.");
  AST_PME_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_reset && pme_enable && !reg_wr) |=> irq_en_q == $past(irq_en_q)) else $error("Mask lost under PME.");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 status_change_interrupt == $past(irq_global_en && (|unmasked))) else $error("Interrupt mismatch.");
  AST_PWR_EVENT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($changed(socket_power_state) && !soft_clear) |=> flags_q[`SEM_BIT_PWR]) else $error("Power change missed.");
  AST_READ_HI: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 reg_rdata[31:`SEM_NBITS] == '0) else $error("Reserved bits not zero.");

  // Register access steps that several properties below share.
  sequence s_flag_write;
    reg_wr && reg_addr == `SEM_OFS_FLAGS;
  endsequence

  sequence s_mask_write;
    reg_wr && reg_addr == `SEM_OFS_IRQ_EN;
  endsequence

  sequence s_flag_read;
    reg_rd && reg_addr == `SEM_OFS_FLAGS;
  endsequence

  sequence s_mask_read;
    reg_rd && reg_addr == `SEM_OFS_IRQ_EN;
  endsequence

  // Card reset has just ended and no bus reset overrides the re-check.
  sequence s_card_reset_exit;
    reset_exit && !soft_clear;
  endsequence

  // A written enable value is stored as given.
  AST_MASK_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_mask_write ##0 !soft_clear
    |=> irq_en_q == $past(reg_wdata[`SEM_NBITS-1:0]))
    else $error("Enable write did not land.");

  AST_MASK_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!(reg_wr && reg_addr == `SEM_OFS_IRQ_EN) && !soft_clear)
    |=> $stable(irq_en_q))
    else $error("Enable changed without a write.");

  AST_FLAG_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_flag_read
    |=> reg_rdata == {`SEM_ZERO_HI, $past(flags_q)})
    else $error("Flag read returned wrong data.");

  AST_MASK_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_mask_read
    |=> reg_rdata == {`SEM_ZERO_HI, $past(irq_en_q)})
    else $error("Enable read returned wrong data.");

  AST_W0_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_flag_write ##0 (!soft_clear && flags_q[`SEM_BIT_CD2] && !reg_wdata[`SEM_BIT_CD2])
    |=> flags_q[`SEM_BIT_CD2])
    else $error("Written zero disturbed a flag.");

  AST_W1C_CSTS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_flag_write ##0 (reg_wdata[`SEM_BIT_CSTS] && !set_req[`SEM_BIT_CSTS])
    |=> !flags_q[`SEM_BIT_CSTS])
    else $error("Write of one left card status flag set.");

  AST_FORCE_CD1: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (force_wr && !soft_clear && force_bits[`SEM_BIT_CD1])
    |=> flags_q[`SEM_BIT_CD1])
    else $error("Force write did not set detect flag.");

  // Level changes on the monitored lines, and a forced event under a clear mask bit.
  AST_CD1_EVENT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($changed(detect_one_state) && !soft_clear)
    |=> flags_q[`SEM_BIT_CD1])
    else $error("First detect change missed.");

  AST_CD2_EVENT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($changed(detect_two_state) && !soft_clear)
    |=> flags_q[`SEM_BIT_CD2])
    else $error("Second detect change missed.");

  AST_CSTS_RISE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($rose(card_status_state) && !soft_clear)
    |=> flags_q[`SEM_BIT_CSTS])
    else $error("Card status rise missed.");

  AST_CSTS_FALL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($fell(card_status_state) && card_is_16bit && !soft_clear)
    |=> flags_q[`SEM_BIT_CSTS])
    else $error("Card status fall missed on a 16-bit card.");

  AST_CSTS_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($fell(card_status_state) && !card_is_16bit && !flags_q[`SEM_BIT_CSTS] && !force_wr)
    |=> !flags_q[`SEM_BIT_CSTS])
    else $error("Card status fall set the flag on a bus-mastering card.");

  AST_MASK_IGNORED: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (force_wr && !soft_clear && force_bits[`SEM_BIT_PWR] && !irq_en_q[`SEM_BIT_PWR])
    |=> flags_q[`SEM_BIT_PWR])
    else $error("Masked event did not set its flag.");

  // Re-check of status when card reset ends.
  AST_EXIT_CD1: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_card_reset_exit ##0 detect_one_state
    |=> flags_q[`SEM_BIT_CD1])
    else $error("First detect not reported after card reset.");

  AST_EXIT_CD2: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_card_reset_exit ##0 detect_two_state
    |=> flags_q[`SEM_BIT_CD2])
    else $error("Second detect not reported after card reset.");

  // Interrupt gating and bus reset under power-management events.
  AST_IRQ_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !irq_global_en
    |=> !status_change_interrupt)
    else $error("Interrupt raised while disabled.");

  AST_IRQ_ON: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (irq_global_en && flags_q[`SEM_BIT_CSTS] && irq_en_q[`SEM_BIT_CSTS])
    |=> status_change_interrupt)
    else $error("Enabled pending flag raised no interrupt.");

  AST_CD_BLOCKED: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!irq_en_q[`SEM_BIT_PWR] && !irq_en_q[`SEM_BIT_CSTS] && !(irq_en_q[`SEM_BIT_CD2] && irq_en_q[`SEM_BIT_CD1]))
    |=> !status_change_interrupt)
    else $error("Blocked detect flags raised an interrupt.");

  AST_PME_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (bus_reset && pme_enable && flags_q[`SEM_BIT_CSTS] && !reg_wr)
    |=> flags_q[`SEM_BIT_CSTS])
    else $error("Flag lost to bus reset under power events.");
endmodule

/* File: sem_map.svh */
// Register offsets, field positions and reset values of the socket event block.
`ifndef SEM_MAP_SVH
`define SEM_MAP_SVH
`define SEM_OFS_FLAGS 8'h00
`define SEM_OFS_IRQ_EN 8'h04
`define SEM_BIT_CSTS 0
`define SEM_BIT_CD1 1
`define SEM_BIT_CD2 2
`define SEM_BIT_PWR 3
`define SEM_NBITS 4
`define SEM_RST_FLAGS 4'h0
`define SEM_RST_IRQ_EN 4'h0
`define SEM_ZERO_HI 28'h0000000
`endif

/* File: sem_pkg.sv */
// Types shared by the socket event block.
package sem_pkg;
  typedef logic [3:0] sem_bits_t;
  typedef logic [31:0] sem_word_t;
  typedef logic [7:0] sem_addr_t;
endpackage

/* File: sem_edge.sv */
// Change detector for one monitored status line.
`timescale 1ns/1ps
module sem_edge (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Monitored level and edge selection.
  input wire logic level,
  input wire logic rise_only,
  // One-cycle pulse when the level changes as selected.
  output logic change
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign change = rise_only ? (level & ~prev_q) : (level ^ prev_q);
endmodule

/* File: sem_host.sv */
// Host software model that reaches the socket event registers.
`timescale 1ns/1ps
module sem_host (
  // Clock.
  input wire logic clk_sys,
  // Register access port.
  output sem_pkg::sem_addr_t reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output sem_pkg::sem_word_t reg_wdata,
  input wire sem_pkg::sem_word_t reg_rdata
);
  import sem_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h00000000;
  end
  task automatic wr(input sem_addr_t a, input sem_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input sem_addr_t a, output sem_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Stale flags are cleared first so that opening the enable raises nothing old.
  task automatic arm(input sem_word_t m);
    wr(8'h00, 32'h0000000f);
    wr(8'h04, m);
  endtask
endmodule

/* File: sem_top_tb.sv */
// Self-checking bench for the socket event block.
`timescale 1ns/1ps
module sem_top_tb;
  import sem_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, bus_reset = 1'b0, pme_enable = 1'b0, force_wr = 1'b0;
  logic pwr = 1'b0, d1 = 1'b0, d2 = 1'b0, cs = 1'b0, c16 = 1'b0, crst = 1'b0, gen = 1'b0, irq;
  logic reg_wr, reg_rd;
  sem_bits_t force_bits = 4'h0;
  sem_addr_t reg_addr;
  sem_word_t reg_wdata, reg_rdata;
  int miscompares = 0, tests_run = 0, cycles = 0;
  always #25 clk_sys = ~clk_sys;
  sem_host i_sem_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  sem_top i_sem_top (.clk_sys(clk_sys), .reset_n(reset_n), .bus_reset(bus_reset), .pme_enable(pme_enable),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .force_wr(force_wr), .force_bits(force_bits), .socket_power_state(pwr), .detect_one_state(d1),
    .detect_two_state(d2), .card_status_state(cs), .card_is_16bit(c16), .card_reset(crst),
    .irq_global_en(gen), .status_change_interrupt(irq));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input sem_word_t s, input sem_word_t e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rdc(input sem_addr_t a, input sem_word_t e);
    sem_word_t d;
    i_sem_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic force_ev(input sem_bits_t b);
    @(posedge clk_sys);
    force_wr <= 1'b1;
    force_bits <= b;
    @(posedge clk_sys);
    force_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_sources();
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    @(posedge clk_sys);
    {pwr, d2, d1, cs} <= 4'hf;
    gen <= 1'b1;
    step(3);
    rdc(8'h00, 32'hf);
    chk({31'h0, irq}, 32'h0);
    i_sem_host.wr(8'h00, 32'h0);
    rdc(8'h00, 32'hf);
    i_sem_host.wr(8'h00, 32'h5);
    rdc(8'h00, 32'ha);
    i_sem_host.wr(8'h04, 32'hffffffff);
    rdc(8'h04, 32'hf);
    i_sem_host.wr(8'h00, 32'hffffffff);
    rdc(8'h00, 32'h0);
    $display("sources done");
  endtask
  task automatic t_mask();
    sem_bits_t m[4] = '{4'h1, 4'h6, 4'h8, 4'h2};
    sem_bits_t f[4] = '{4'h1, 4'h6, 4'h8, 4'h6};
    for (int k = 0; k < 4; k++) begin
      i_sem_host.arm({28'h0, m[k]});
      force_ev(~f[k]);
      chk({31'h0, irq}, 32'h0);
      force_ev(f[k]);
      chk({31'h0, irq}, {31'h0, k < 3});
    end
    $display("mask done");
  endtask
  task automatic t_edges();
    // A detect change lands on the same edge as the clearing write.
    fork
      i_sem_host.wr(8'h00, 32'hf);
      begin
        @(posedge clk_sys);
        d1 <= 1'b0;
      end
    join
    rdc(8'h00, 32'h2);
    @(posedge clk_sys);
    d1 <= 1'b1;
    i_sem_host.wr(8'h00, 32'hf);
    @(posedge clk_sys);
    cs <= 1'b0;
    step(3);
    rdc(8'h00, 32'h0);
    @(posedge clk_sys);
    c16 <= 1'b1;
    cs <= 1'b1;
    step(3);
    i_sem_host.wr(8'h00, 32'hf);
    cs <= 1'b0;
    step(3);
    rdc(8'h00, 32'h1);
    $display("edges done");
  endtask
  task automatic t_resets();
    i_sem_host.wr(8'h04, 32'hf);
    pme_enable <= 1'b1;
    bus_reset <= 1'b1;
    step(2);
    bus_reset <= 1'b0;
    rdc(8'h00, 32'h1);
    rdc(8'h04, 32'hf);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk_sys);
    gen <= 1'b0;
    step(2);
    #1;
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    gen <= 1'b1;
    pme_enable <= 1'b0;
    bus_reset <= 1'b1;
    step(2);
    bus_reset <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    @(posedge clk_sys);
    crst <= 1'b1;
    step(2);
    crst <= 1'b0;
    step(3);
    rdc(8'h00, 32'h6);
    $display("resets done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_sources();
    t_mask();
    t_edges();
    t_resets();
    finish_test();
  end
endmodule
